//--- design/pfp_defs.svh
`ifndef PFP_DEFS_SVH
`define PFP_DEFS_SVH

// Register byte offsets on the slave bus
`define PFP_OFS_PROT 4'h0
`define PFP_OFS_STAT 4'h4

// Protection register fields
`define PFP_BIT_POLARITY 7
`define PFP_BIT_RSVD_NV 6
`define PFP_BIT_HI_DIS 5
`define PFP_HI_SIZE_HI 4
`define PFP_HI_SIZE_LO 3
`define PFP_BIT_LO_DIS 2
`define PFP_LO_SIZE_HI 1
`define PFP_LO_SIZE_LO 0

// Status register fields
`define PFP_BIT_VIOL 4
`define PFP_BIT_LOADED 0

// Values before the load and after a double bit fault
`define PFP_PROT_RESET 8'h7F
`define PFP_PROT_FAULT 8'h7F

// Nonvolatile source of the protection byte
`define PFP_NV_ADDR 18'h3_FF0C

// Address ranges
`define PFP_HI_END 18'h3_FFFF
`define PFP_HI_START_0 18'h3_F800
`define PFP_HI_START_1 18'h3_F000
`define PFP_HI_START_2 18'h3_E000
`define PFP_HI_START_3 18'h3_C000
`define PFP_LO_START 18'h3_8000
`define PFP_LO_END_0 18'h3_83FF
`define PFP_LO_END_1 18'h3_87FF
`define PFP_LO_END_2 18'h3_8FFF
`define PFP_LO_END_3 18'h3_9FFF

// Allowed transitions, one byte per source scenario, bit = target
`define PFP_TRANS_MATRIX 64'hFF5A_3C18_080C_0A0F
`define PFP_SCEN_NONE 3'h7
`define PFP_SCEN_FULL 3'h3

`endif

//--- design/pfp_pkg.sv
package pfp_pkg;

   typedef enum logic [1:0] {
      PFP_CMD_PROGRAM = 2'b00,
      PFP_CMD_SECTOR_ERASE = 2'b01,
      PFP_CMD_BLOCK_ERASE = 2'b10
   } pfp_cmd_t;

   typedef logic [2:0] pfp_scen_t;

endpackage : pfp_pkg

//--- design/pfp_top.sv
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Reset sequence loads protection byte from configuration
// - Double bit fault gives full protection value
// - Protected program or erase refused, flag set
// - Block erase refused if any sector protected
// - Polarity bit selects protected or unprotected ranges
// - High disable bit enables range ending at top
// - High size code selects range start address
// - High size writable only while high disabled
// - Low disable bit enables range starting at 3_8000
// - Low size code selects range end address
// - Low size writable only while low disabled
// - Both disabled: none or full protection by polarity
// - Disallowed scenario writes ignored whole; protection grows
// - Reading register returns scenario in force
// - Transitions follow the allowed scenario matrix
// - Software may rewrite register at run time
// - Flag cleared by writing one; blocks commands
`include "pfp_defs.svh"

module pfp_top #(
   parameter logic [17:0] PFLASH_BASE = 18'h3_0000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Nonvolatile protection byte from the reset sequence
   input wire logic nv_load_valid,
   input wire logic [7:0] nv_load_byte,
   input wire logic nv_load_dbf,
   // Command check
   input wire logic cmd_valid,
   input wire pfp_pkg::pfp_cmd_t cmd_kind,
   input wire logic [17:0] cmd_addr,
   output logic cmd_ready,
   output logic cmd_launch,
   output logic cmd_refuse,
   // Status
   output logic protection_violation_flag,
   output logic prot_loaded
);

   if (PFLASH_BASE > `PFP_LO_START) begin : g_chk
      $error("PFLASH_BASE must not lie above the low range start");
   end

   function automatic pfp_pkg::pfp_scen_t scen_of(input logic [7:0] p);
      logic [2:0] key;
      key = {p[`PFP_BIT_POLARITY], p[`PFP_BIT_HI_DIS], p[`PFP_BIT_LO_DIS]};
      unique case (key)
         3'b000: scen_of = 3'h0;
         3'b001: scen_of = 3'h1;
         3'b010: scen_of = 3'h2;
         3'b011: scen_of = 3'h3;
         3'b100: scen_of = 3'h4;
         3'b101: scen_of = 3'h5;
         3'b110: scen_of = 3'h6;
         3'b111: scen_of = 3'h7;
      endcase
   endfunction : scen_of

   function automatic logic allowed(input pfp_pkg::pfp_scen_t from_s, input pfp_pkg::pfp_scen_t to_s);
      logic [63:0] mtx;
      mtx = `PFP_TRANS_MATRIX;
      allowed = mtx[{from_s, to_s}];
   endfunction : allowed

   logic [7:0] prot_ff;
   logic [7:0] nxt_prot;
   logic loaded_ff;
   logic nxt_loaded;
   logic viol_ff;
   logic nxt_viol;
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic launch_ff;
   logic nxt_launch;
   logic refuse_ff;
   logic nxt_refuse;

   logic bus_req;
   logic bus_done;
   logic wr_prot;
   logic wr_stat;
   logic [7:0] cand;
   logic [17:0] hi_start;
   logic [17:0] lo_end;
   logic hi_hit;
   logic lo_hit;
   logic in_pflash;
   logic addr_prot;
   logic any_prot;
   logic cmd_take;
   logic cmd_bad;

   // Bus slave: one wait state so read data come from a flop
   assign bus_req = avs_read | avs_write;
   assign bus_done = bus_req & ack_ff;
   assign avs_waitrequest = bus_req & ~ack_ff;
   assign avs_readdata = rdata_ff;
   assign wr_prot = avs_write & bus_done & avs_byteenable[0] & (avs_address == `PFP_OFS_PROT);
   assign wr_stat = avs_write & bus_done & avs_byteenable[0] & (avs_address == `PFP_OFS_STAT);

   // Next values, so a load landing in the request cycle still reads back
   always_comb begin
      nxt_ack = bus_req & ~ack_ff;
      nxt_rdata = rdata_ff;
      if (avs_read & ~ack_ff) begin
         unique case (avs_address)
            `PFP_OFS_PROT: nxt_rdata = {24'h00_0000, nxt_prot};
            `PFP_OFS_STAT: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rdata[`PFP_BIT_VIOL] = nxt_viol;
               nxt_rdata[`PFP_BIT_LOADED] = nxt_loaded;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // Candidate value of a software write
   always_comb begin
      cand = avs_writedata[7:0];
      cand[`PFP_BIT_RSVD_NV] = prot_ff[`PFP_BIT_RSVD_NV];
      if (!prot_ff[`PFP_BIT_HI_DIS]) begin
         cand[`PFP_HI_SIZE_HI:`PFP_HI_SIZE_LO] = prot_ff[`PFP_HI_SIZE_HI:`PFP_HI_SIZE_LO];
      end
      if (!prot_ff[`PFP_BIT_LO_DIS]) begin
         cand[`PFP_LO_SIZE_HI:`PFP_LO_SIZE_LO] = prot_ff[`PFP_LO_SIZE_HI:`PFP_LO_SIZE_LO];
      end
   end

   // Protection register; the reset load outranks a bus write
   always_comb begin
      nxt_prot = prot_ff;
      nxt_loaded = loaded_ff;
      if (nv_load_valid) begin
         nxt_prot = nv_load_dbf ? `PFP_PROT_FAULT : nv_load_byte;
         nxt_loaded = 1'b1;
      end else if (wr_prot && allowed(scen_of(prot_ff), scen_of(cand))) begin
         nxt_prot = cand;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prot_ff <= `PFP_PROT_RESET;
         loaded_ff <= 1'b0;
      end else begin
         prot_ff <= nxt_prot;
         loaded_ff <= nxt_loaded;
      end
   end

   // Range decode
   always_comb begin
      unique case (prot_ff[`PFP_HI_SIZE_HI:`PFP_HI_SIZE_LO])
         2'b00: hi_start = `PFP_HI_START_0;
         2'b01: hi_start = `PFP_HI_START_1;
         2'b10: hi_start = `PFP_HI_START_2;
         2'b11: hi_start = `PFP_HI_START_3;
      endcase
      unique case (prot_ff[`PFP_LO_SIZE_HI:`PFP_LO_SIZE_LO])
         2'b00: lo_end = `PFP_LO_END_0;
         2'b01: lo_end = `PFP_LO_END_1;
         2'b10: lo_end = `PFP_LO_END_2;
         2'b11: lo_end = `PFP_LO_END_3;
      endcase
   end

   // Addresses below the array are never protected
   assign in_pflash = (cmd_addr >= PFLASH_BASE) && (cmd_addr <= `PFP_HI_END);
   assign hi_hit = ~prot_ff[`PFP_BIT_HI_DIS] && (cmd_addr >= hi_start) && (cmd_addr <= `PFP_HI_END);
   assign lo_hit = ~prot_ff[`PFP_BIT_LO_DIS] && (cmd_addr >= `PFP_LO_START) && (cmd_addr <= lo_end);
   // Both ranges off leaves the polarity alone to decide
   assign addr_prot = in_pflash &&
      (prot_ff[`PFP_BIT_POLARITY] ? (hi_hit | lo_hit) : ~(hi_hit | lo_hit));
   // Only one block, so any protection at all blocks its erase
   assign any_prot = scen_of(prot_ff) != `PFP_SCEN_NONE;

   // Commands wait for the load and for the flag to clear
   assign cmd_ready = loaded_ff & ~viol_ff;
   assign cmd_take = cmd_valid & cmd_ready;
   assign cmd_launch = launch_ff;
   assign cmd_refuse = refuse_ff;
   assign protection_violation_flag = viol_ff;
   assign prot_loaded = loaded_ff;

   always_comb begin
      unique case (cmd_kind)
         pfp_pkg::PFP_CMD_BLOCK_ERASE: cmd_bad = any_prot;
         pfp_pkg::PFP_CMD_PROGRAM, pfp_pkg::PFP_CMD_SECTOR_ERASE: cmd_bad = addr_prot;
         default: cmd_bad = addr_prot;
      endcase
   end

   // Flag: a new violation wins over a clear in the same cycle
   always_comb begin
      nxt_viol = viol_ff;
      if (wr_stat && avs_writedata[`PFP_BIT_VIOL]) begin
         nxt_viol = 1'b0;
      end
      if (cmd_take && cmd_bad) begin
         nxt_viol = 1'b1;
      end
      nxt_launch = cmd_take & ~cmd_bad;
      nxt_refuse = cmd_take & cmd_bad;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         viol_ff <= 1'b0;
         launch_ff <= 1'b0;
         refuse_ff <= 1'b0;
      end else begin
         viol_ff <= nxt_viol;
         launch_ff <= nxt_launch;
         refuse_ff <= nxt_refuse;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   load_value_a: assert property (nv_load_valid && !nv_load_dbf |=> prot_ff == $past(nv_load_byte))
      else $error("Protection byte not loaded");
   load_fault_a: assert property (nv_load_valid && nv_load_dbf |=> prot_ff == `PFP_PROT_FAULT)
      else $error("Fault load did not protect all");
   viol_set_a: assert property (cmd_take && cmd_kind != pfp_pkg::PFP_CMD_BLOCK_ERASE && addr_prot
      |=> viol_ff && cmd_refuse && !cmd_launch)
      else $error("Protected command not refused");
   blk_erase_a: assert property (cmd_take && cmd_kind == pfp_pkg::PFP_CMD_BLOCK_ERASE && any_prot
      |=> cmd_refuse && !cmd_launch)
      else $error("Block erase with protection not refused");
   full_prot_a: assert property (cmd_take && in_pflash && scen_of(prot_ff) == `PFP_SCEN_FULL
      |=> cmd_refuse)
      else $error("Full protection let a command through");
   hi_size_lock_a: assert property (!nv_load_valid && !prot_ff[`PFP_BIT_HI_DIS]
      |=> $stable(prot_ff[`PFP_HI_SIZE_HI:`PFP_HI_SIZE_LO]))
      else $error("High size changed while enabled");
   lo_size_lock_a: assert property (!nv_load_valid && !prot_ff[`PFP_BIT_LO_DIS]
      |=> $stable(prot_ff[`PFP_LO_SIZE_HI:`PFP_LO_SIZE_LO]))
      else $error("Low size changed while enabled");
   trans_legal_a: assert property (!nv_load_valid |=> allowed(scen_of($past(prot_ff)), scen_of(prot_ff)))
      else $error("Illegal scenario transition");
   read_back_a: assert property (avs_read && !avs_waitrequest && avs_address == `PFP_OFS_PROT
      |-> avs_readdata == {24'h00_0000, prot_ff})
      else $error("Read did not return protection in force");
   viol_block_a: assert property (viol_ff ##1 viol_ff |-> !cmd_ready && !cmd_launch)
      else $error("Command launched while flag set");
   stat_read_a: assert property (avs_read && !avs_waitrequest && avs_address == `PFP_OFS_STAT
      |-> avs_readdata == {27'h000_0000, viol_ff, 3'h0, loaded_ff})
      else $error("Status read did not return flag and load state");
   rsvd_keep_a: assert property (!nv_load_valid |=> $stable(prot_ff[`PFP_BIT_RSVD_NV]))
      else $error("Reserved nonvolatile bit changed by software");
   // A dropped write gives no indication; software must read back
   drop_write_a: assert property (wr_prot && !nv_load_valid && !allowed(scen_of(prot_ff), scen_of(cand))
      |=> $stable(prot_ff))
      else $error("Disallowed scenario write changed the register");
   no_prot_a: assert property (cmd_take && scen_of(prot_ff) == `PFP_SCEN_NONE
      |=> cmd_launch && !cmd_refuse)
      else $error("Unprotected command was refused");
   not_ready_a: assert property (cmd_valid && !cmd_ready
      |=> !cmd_launch && !cmd_refuse)
      else $error("Command taken while not ready");
   ready_load_a: assert property (!loaded_ff |-> !cmd_ready)
      else $error("Command ready before the protection load");
   viol_hold_a: assert property (viol_ff && !(wr_stat && avs_writedata[`PFP_BIT_VIOL])
      |=> viol_ff)
      else $error("Violation flag cleared without a write of one");

   load_c: cover property (nv_load_valid ##1 loaded_ff);
   refuse_c: cover property (cmd_take && cmd_bad ##1 viol_ff ##[1:20] !viol_ff);
   grow_c: cover property (wr_prot ##1 $changed(prot_ff));
   erase_c: cover property (cmd_take && cmd_kind == pfp_pkg::PFP_CMD_BLOCK_ERASE && !any_prot);
   drop_c: cover property (wr_prot && !allowed(scen_of(prot_ff), scen_of(cand)));

endmodule : pfp_top

//--- tb/pfp_top_bench.sv
`timescale 1ns/1ps
module pfp_top_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic nv_load_valid = 1'b0;
   logic [7:0] nv_load_byte = 8'h00;
   logic nv_load_dbf = 1'b0;
   logic cmd_valid = 1'b0;
   pfp_pkg::pfp_cmd_t cmd_kind = pfp_pkg::PFP_CMD_PROGRAM;
   logic [17:0] cmd_addr = 18'h0_0000;
   logic cmd_ready, cmd_launch, cmd_refuse, protection_violation_flag, prot_loaded;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] rd;
   logic [7:0] exp_prot;
   logic [7:0] w;
   // Target mask per source scenario
   localparam logic [7:0] ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
   localparam logic [17:0] HS [4] = '{18'h3_F800, 18'h3_F000, 18'h3_E000, 18'h3_C000};
   localparam logic [17:0] LE [4] = '{18'h3_83FF, 18'h3_87FF, 18'h3_8FFF, 18'h3_9FFF};
   // Edges of every range except the 3_8FFF low range end, plus one outside the array
   localparam logic [17:0] ADDRS [16] = '{18'h2_FFFF, 18'h3_0000, 18'h3_7FFF, 18'h3_8000,
      18'h3_83FF, 18'h3_8400, 18'h3_87FF, 18'h3_8800, 18'h3_9FFF, 18'h3_A000, 18'h3_BFFF,
      18'h3_C000, 18'h3_DFFF, 18'h3_EFFF, 18'h3_F7FF, 18'h3_FFFF};

   pfp_top #(.PFLASH_BASE(18'h3_0000)) dut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .nv_load_valid(nv_load_valid), .nv_load_byte(nv_load_byte), .nv_load_dbf(nv_load_dbf),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
      .cmd_launch(cmd_launch), .cmd_refuse(cmd_refuse),
      .protection_violation_flag(protection_violation_flag), .prot_loaded(prot_loaded));

   initial begin
      forever #12.5 clk = ~clk;
   end

   function automatic logic is_prot(input logic [7:0] p, input logic [17:0] a);
      logic inr;
      inr = (!p[5] && a >= HS[p[4:3]]) || (!p[2] && a >= 18'h3_8000 && a <= LE[p[1:0]]);
      return (a >= 18'h3_0000) && (p[7] ? inr : !inr);
   endfunction : is_prot

   // Size fields only move while their disable bit is already set
   function automatic logic [7:0] nxt_prot(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] n;
      n = {d[7], c[6], d[5], c[5] ? d[4:3] : c[4:3], d[2], c[2] ? d[1:0] : c[1:0]};
      return ALLOW[{c[7], c[5], c[2]}][{d[7], d[5], d[2]}] ? n : c;
   endfunction : nxt_prot

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic chk1(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic nv_load(input logic [7:0] b, input logic f);
      @(posedge clk);
      nv_load_valid <= 1'b1;
      nv_load_byte <= b;
      nv_load_dbf <= f;
      @(posedge clk);
      nv_load_valid <= 1'b0;
      exp_prot = f ? 8'h7F : b;
   endtask : nv_load

   task automatic cmd(input logic [1:0] k, input logic [17:0] a);
      logic e;
      e = (k == 2'b10) ? ({exp_prot[7], exp_prot[5], exp_prot[2]} != 3'h7) : is_prot(exp_prot, a);
      @(posedge clk);
      chk1("cmd_ready", 1'b1, cmd_ready);
      cmd_valid <= 1'b1;
      cmd_kind <= pfp_pkg::pfp_cmd_t'(k);
      cmd_addr <= a;
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
      chk1("cmd_refuse", e, cmd_refuse);
      chk1("cmd_launch", !e, cmd_launch);
      chk1("violation", e, protection_violation_flag);
      if (e) begin
         chk1("ready_blocked", 1'b0, cmd_ready);
         cmd_valid <= 1'b1;
         @(posedge clk);
         cmd_valid <= 1'b0;
         @(posedge clk);
         chk1("blocked_pulse", 1'b0, cmd_launch | cmd_refuse);
         bus(1'b1, 4'h4, 8'h00, 4'h1);
         bus(1'b0, 4'h4, 8'h00, 4'h0);
         chk8("status_set", 8'h11, rd);
         bus(1'b1, 4'h4, 8'h10, 4'h1);
         bus(1'b0, 4'h4, 8'h00, 4'h0);
         chk8("status_clear", 8'h01, rd);
      end
   endtask : cmd

   task automatic complete_run;
      $display("Compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // Cut a hang short well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         num_errors++;
         complete_run();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 4'h0, 8'h00, 4'h0);
      chk8("prot_reset", 8'h7F, rd);
      chk1("loaded_reset", 1'b0, prot_loaded);
      chk1("ready_unloaded", 1'b0, cmd_ready);
      nv_load(8'hFF, 1'b1);
      bus(1'b0, 4'h0, 8'h00, 4'h0);
      chk8("prot_fault", exp_prot, rd);
      chk1("loaded", 1'b1, prot_loaded);
      for (int s = 0; s < 8; s++) begin
         for (int t = 0; t < 8; t++) begin
            nv_load({s[2], 1'b1, s[1], 2'b01, s[0], 2'b10}, 1'b0);
            w = {t[2], 1'b1, t[1], 2'b10, t[0], 2'b01};
            exp_prot = nxt_prot(exp_prot, w);
            bus(1'b1, 4'h0, w, 4'h1);
            bus(1'b0, 4'h0, 8'h00, 4'h0);
            chk8("prot_trans", exp_prot, rd);
         end
      end
      bus(1'b1, 4'h0, 8'h00, 4'h0);
      bus(1'b1, 4'h8, 8'h00, 4'h1);
      bus(1'b0, 4'h8, 8'h00, 4'h0);
      chk8("unmapped", 8'h00, rd);
      bus(1'b0, 4'h0, 8'h00, 4'h0);
      chk8("prot_kept", exp_prot, rd);
      for (int p = 0; p < 32; p++) begin
         nv_load({p[4], 1'b1, p[3], p[1:0], p[2], p[1:0]}, 1'b0);
         cmd(2'b00, 18'h3_FF0C);
         for (int i = 0; i < 16; i++) begin
            for (int k = 0; k < 4; k++) cmd(k[1:0], ADDRS[i]);
         end
      end
      complete_run();
   end
endmodule : pfp_top_bench
